//--- src/crd_pkg.sv
/*
 * Constants for the range-routing, debug-override and prefetch control
 * block of the level 2 cache controller.
 * Assumes a 32-bit APB register bus and 32-byte cache lines.
 */
package crd_pkg;

    // =========================================================
    // Register byte offsets
    localparam logic [7:0] CRD_OFF_START = 8'h00;
    localparam logic [7:0] CRD_OFF_END = 8'h04;
    localparam logic [7:0] CRD_OFF_DEBUG = 8'h08;
    localparam logic [7:0] CRD_OFF_PFOFF = 8'h0c;
    localparam logic [7:0] CRD_OFF_AUX = 8'h10;

    // =========================================================
    // Field positions
    localparam int CRD_RANGE_LSB = 20;
    localparam int CRD_RANGE_W = 12;
    localparam int CRD_EN_BIT = 0;
    localparam int CRD_SNI_BIT = 2;
    localparam int CRD_FWT_BIT = 1;
    localparam int CRD_LFD_BIT = 0;
    localparam int CRD_PFOFF_W = 5;
    localparam int CRD_AUX_PF_HI = 29;
    localparam int CRD_AUX_PF_LO = 28;
    localparam int CRD_LINE_LSB = 5;
    localparam int CRD_PAGE_LSB = 12;

    // =========================================================
    // Reset values
    localparam logic CRD_FWT_RST = 1'b0;
    localparam logic CRD_LFD_RST = 1'b0;
    localparam logic [4:0] CRD_PFOFF_RST = 5'h00;
    localparam logic [1:0] CRD_AUX_PF_RST = 2'h0;

    // =========================================================
    // Register index decode
    typedef enum {
        CRD_REG_START,
        CRD_REG_END,
        CRD_REG_DEBUG,
        CRD_REG_PFOFF,
        CRD_REG_AUX,
        CRD_REG_NONE
    } crd_reg_type;

endpackage : crd_pkg

//--- src/crd_ctl.sv
/*
 * Range routing to master port one, debug overrides (forced
 * write-through, linefill disable) and next-line prefetch control.
 * Assumes an APB master on clk, a request source on the same clock
 * and static tied reset-default inputs.
 */
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
// Summary of operation
// - Redirection to master port one only when two master ports exist.
// - Enabled redirection sends start <= addr < end to port one.
// - Start register: start in 31:20, enable in bit 0, rest zero.
// - Start and enable load reset-default inputs on reset.
// - End register read/write, end in 31:20, low bits read zero.
// - End field loads reset-default end input on reset.
// - Debug register readable by all, non-secure write gets error.
// - Debug bit 2 secure debug input, bit 1 write-through, bit 0 fill.
// - Forced write-through makes cacheable writes through, no allocate.
// - Dirty lines stay dirty during forced write-through.
// - Clean line written under forced write-through stays clean.
// - Forced write-through write hit to dirty line updates cache and memory.
// - Linefill disable stops allocation on reads and writes.
// - With fills off, hits read cache, misses fetch only words.
// - Overrides beat forced write-allocate and exclusive mode.
// - Prefetch enable bits make cacheable reads look up later line.
// - Prefetch line is request line plus one plus offset.
// - Prefetch miss fetches and allocates the line unless linefill is disabled.
// - Prefetch offset resets to zero, upper bits read zero.
// - No prefetch across a 4KB boundary.
// - One clock, active-low reset, ports sampled on their enables.
module crd_ctl
    import crd_pkg::*;
#(
    parameter bit TWO_MASTERS = 1'b1
) (
    // Clock, reset, freeze
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Reset-default straps, live debug and allocation config inputs
    input wire logic [11:0] reset_range_start_in,
    input wire logic reset_range_enable_in,
    input wire logic [11:0] reset_range_end_in,
    input wire logic secure_noninvasive_debug_in,
    input wire logic force_walloc_in,
    input wire logic exclusive_cfg_in,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [2:0] pprot,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Slave port request, per-port clock enables
    input wire logic slave_zero_input_clk_en,
    input wire logic slave_zero_output_clk_en,
    input wire logic req_valid,
    input wire logic [31:0] req_addr,
    input wire logic req_write,
    input wire logic req_cacheable,
    input wire logic req_write_back,
    input wire logic req_alloc,
    input wire logic req_hit,
    input wire logic req_line_dirty,
    output logic req_ready,
    // Access decision
    output logic dec_valid,
    output logic dec_route_one,
    output logic dec_write_through,
    output logic dec_allocate,
    output logic dec_line_dirty,
    output logic dec_mem_write,
    output logic dec_cache_write,
    output logic dec_words_only,
    // Prefetch
    output logic pf_valid,
    output logic [31:0] pf_addr,
    input wire logic pf_result_valid,
    input wire logic pf_result_miss,
    output logic pf_fill
);

    // =========================================================
    // State
    typedef struct packed {
        logic loaded;
        logic [11:0] start;
        logic en;
        logic [11:0] fin;
        logic fwt;
        logic lfd;
        logic [4:0] pf_off;
        logic [1:0] pf_en;
        logic [2:0] sni_sync;
        logic sni;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic pend;
        logic [31:0] addr;
        logic wr;
        logic cach;
        logic wb;
        logic alloc;
        logic hit;
        logic dirty;
        logic req_ready;
        logic dec_valid;
        logic route_one;
        logic wt;
        logic dalloc;
        logic ddirty;
        logic mem_wr;
        logic cache_wr;
        logic words_only;
        logic pf_valid;
        logic [31:0] pf_addr;
        logic pf_fill;
    } crd_state_type;

    crd_state_type st;
    crd_state_type next_st;
    logic [1:0] rst_sync;
    logic rst_ok;

    // =========================================================
    // Reset release
    // global reset sync
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_ok = rst_sync[1];

    function automatic crd_reg_type reg_of(input logic [31:0] a);
        unique case (a[7:0])
            CRD_OFF_START: reg_of = CRD_REG_START;
            CRD_OFF_END: reg_of = CRD_REG_END;
            CRD_OFF_DEBUG: reg_of = CRD_REG_DEBUG;
            CRD_OFF_PFOFF: reg_of = CRD_REG_PFOFF;
            CRD_OFF_AUX: reg_of = CRD_REG_AUX;
            default: reg_of = CRD_REG_NONE;
        endcase
        if (a[31:8] != 24'h0) begin
            reg_of = CRD_REG_NONE;
        end
    endfunction : reg_of

    // =========================================================
    // Next state
    always_comb begin
        logic [26:0] line;
        logic [26:0] pline;
        logic in_rng;
        logic access;
        logic pf_on;
        crd_reg_type r;
        next_st = st;
        line = st.addr[31:CRD_LINE_LSB];
        pline = 27'(line + 27'(st.pf_off) + 27'h1);
        r = reg_of(paddr);
        access = psel && penable;
        pf_on = |st.pf_en;
        in_rng = 1'b0;
        if (!st.loaded) begin
            next_st.loaded = 1'b1;
            next_st.start = reset_range_start_in;
            next_st.en = reset_range_enable_in;
            next_st.fin = reset_range_end_in;
        end
        // Pin synchroniser, change counted when two stages agree
        next_st.sni_sync = {st.sni_sync[1:0], secure_noninvasive_debug_in};
        if (st.sni_sync[2] == st.sni_sync[1]) begin
            next_st.sni = st.sni_sync[2];
        end
        // APB: one wait state, effect on the pready edge
        next_st.pready = access && !st.pready;
        next_st.pslverr = 1'b0;
        if (access && !st.pready) begin
            next_st.prdata = 32'h0;
            next_st.pslverr = (r == CRD_REG_NONE);
            unique case (r)
                CRD_REG_START: next_st.prdata =
                    {st.start, 19'h0, st.en};
                CRD_REG_END: next_st.prdata = {st.fin, 20'h0};
                CRD_REG_DEBUG: next_st.prdata =
                    {29'h0, st.sni, st.fwt, st.lfd};
                CRD_REG_PFOFF: next_st.prdata = {27'h0, st.pf_off};
                CRD_REG_AUX: next_st.prdata =
                    {2'h0, st.pf_en, 28'h0};
                default: next_st.prdata = 32'h0;
            endcase
            if (pwrite && r == CRD_REG_DEBUG && pprot[1]) begin
                next_st.pslverr = 1'b1;
            end
        end
        if (access && st.pready && pwrite && !st.pslverr) begin
            unique case (r)
                CRD_REG_START: begin
                    next_st.start = pwdata[31:CRD_RANGE_LSB];
                    next_st.en = pwdata[CRD_EN_BIT];
                end
                CRD_REG_END: next_st.fin = pwdata[31:CRD_RANGE_LSB];
                CRD_REG_DEBUG: begin
                    next_st.fwt = pwdata[CRD_FWT_BIT];
                    next_st.lfd = pwdata[CRD_LFD_BIT];
                end
                CRD_REG_PFOFF: next_st.pf_off = pwdata[4:0];
                CRD_REG_AUX: next_st.pf_en =
                    pwdata[CRD_AUX_PF_HI:CRD_AUX_PF_LO];
                default: next_st.pf_off = st.pf_off;
            endcase
        end
        if (slave_zero_input_clk_en && req_valid && st.req_ready) begin
            next_st.pend = 1'b1;
            next_st.addr = req_addr;
            next_st.wr = req_write;
            next_st.cach = req_cacheable;
            next_st.wb = req_write_back;
            next_st.alloc = req_alloc || (req_write && force_walloc_in);
            next_st.hit = req_hit;
            next_st.dirty = req_line_dirty;
        end
        next_st.req_ready = !next_st.pend;
        // Decisions driven only on output enable
        if (slave_zero_output_clk_en) begin
            next_st.dec_valid = 1'b0;
            next_st.pf_valid = 1'b0;
            next_st.pf_fill = 1'b0;
            if (pf_result_valid && pf_result_miss && !st.lfd) begin
                next_st.pf_fill = 1'b1;
            end
            if (st.pend) begin
                next_st.pend = 1'b0;
                next_st.req_ready = 1'b1;
                next_st.dec_valid = 1'b1;
                in_rng = st.addr[31:CRD_RANGE_LSB] >= st.start &&
                    st.addr[31:CRD_RANGE_LSB] < st.fin;
                next_st.route_one = TWO_MASTERS && st.en && in_rng;
                next_st.words_only = 1'b0;
                next_st.ddirty = st.hit && st.dirty;
                if (st.wr) begin
                    next_st.cache_wr = st.hit;
                    if (!st.cach) begin
                        next_st.wt = 1'b1;
                        next_st.dalloc = 1'b0;
                        next_st.mem_wr = 1'b1;
                        next_st.cache_wr = 1'b0;
                    end else if (st.fwt) begin
                        next_st.wt = 1'b1;
                        next_st.dalloc = 1'b0;
                        next_st.mem_wr = 1'b1;
                        next_st.ddirty = st.hit && st.dirty;
                    end else begin
                        next_st.wt = !st.wb;
                        next_st.mem_wr = !st.wb || !st.hit;
                        next_st.ddirty = st.hit && (st.dirty || st.wb);
                        next_st.dalloc = !st.hit && st.alloc && st.wb &&
                            !exclusive_cfg_in;
                    end
                end else begin
                    next_st.wt = 1'b0;
                    next_st.mem_wr = 1'b0;
                    next_st.cache_wr = 1'b0;
                    next_st.dalloc = st.cach && !st.hit && st.alloc &&
                        !exclusive_cfg_in;
                    next_st.words_only = st.cach && !st.hit && st.lfd;
                    if (st.cach && pf_on && pline[26:7] ==
                            line[26:7]) begin
                        next_st.pf_valid = 1'b1;
                        next_st.pf_addr = {pline, 5'h00};
                    end
                end
                if (st.lfd) begin
                    next_st.dalloc = 1'b0;
                end
            end
        end
    end

    // =========================================================
    // Registers; ce low freezes all state except the reset synchroniser
    always_ff @(posedge clk or negedge rst_ok) begin
        if (!rst_ok) begin
            st <= '0;
            st.fwt <= CRD_FWT_RST;
            st.lfd <= CRD_LFD_RST;
            st.pf_off <= CRD_PFOFF_RST;
            st.pf_en <= CRD_AUX_PF_RST;
            st.req_ready <= 1'b0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign req_ready = st.req_ready;
    assign dec_valid = st.dec_valid;
    assign dec_route_one = st.route_one;
    assign dec_write_through = st.wt;
    assign dec_allocate = st.dalloc;
    assign dec_line_dirty = st.ddirty;
    assign dec_mem_write = st.mem_wr;
    assign dec_cache_write = st.cache_wr;
    assign dec_words_only = st.words_only;
    assign pf_valid = st.pf_valid;
    assign pf_addr = st.pf_addr;
    assign pf_fill = st.pf_fill;

    // =========================================================
    // Assertions
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_ok);

    logic decide;
    assign decide = ce && st.pend && slave_zero_output_clk_en;

    property p_route_two;
        dec_route_one |-> TWO_MASTERS;
    endproperty
    a_route_two: assert property (p_route_two)
        else $error("route to port one without two masters");

    property p_route;
        decide |=> dec_route_one == ($past(st.en) &&
            $past(st.addr[31:20]) >= $past(st.start) &&
            $past(st.addr[31:20]) < $past(st.fin) && TWO_MASTERS);
    endproperty
    a_route: assert property (p_route)
        else $error("range routing wrong");

    property p_secure;
        (ce && psel && penable && !pready && pwrite && pprot[1] &&
            paddr == 32'(CRD_OFF_DEBUG)) |=> pslverr ##1
            ($stable(st.fwt) && $stable(st.lfd));
    endproperty
    a_secure: assert property (p_secure)
        else $error("non-secure debug write not refused");

    property p_start_rd;
        (pready && !pwrite && paddr == 32'(CRD_OFF_START)) |->
            prdata[19:1] == 19'h0;
    endproperty
    a_start_rd: assert property (p_start_rd)
        else $error("start reserved bits not zero");

    property p_wt;
        decide && st.fwt && st.wr && st.cach |=>
            dec_write_through && dec_mem_write && !dec_allocate;
    endproperty
    a_wt: assert property (p_wt)
        else $error("forced write-through ignored");

    property p_clean;
        decide && st.fwt && st.wr && st.cach && st.hit && !st.dirty
            |=> !dec_line_dirty;
    endproperty
    a_clean: assert property (p_clean)
        else $error("clean line marked dirty");

    property p_dirty_hit;
        decide && st.fwt && st.wr && st.cach && st.hit && st.dirty
            |=> dec_cache_write && dec_mem_write && dec_line_dirty;
    endproperty
    a_dirty_hit: assert property (p_dirty_hit)
        else $error("dirty hit not written to both");

    property p_nofill;
        decide && st.lfd |=> !dec_allocate;
    endproperty
    a_nofill: assert property (p_nofill)
        else $error("allocation with fills disabled");

    property p_pf_addr;
        decide |=> !pf_valid || pf_addr[31:5] == 27'($past(st.addr[31:5])
            + 27'($past(st.pf_off)) + 27'h1);
    endproperty
    a_pf_addr: assert property (p_pf_addr)
        else $error("prefetch address wrong");

    property p_page;
        decide |=> !pf_valid || pf_addr[31:12] == $past(st.addr[31:12]);
    endproperty
    a_page: assert property (p_page)
        else $error("prefetch crossed 4KB");

    property p_off_rst;
        $rose(rst_ok) |-> st.pf_off == 5'h00;
    endproperty
    a_off_rst: assert property (p_off_rst)
        else $error("prefetch offset not zero at reset");

endmodule : crd_ctl

//--- tb/crd_mem_model.sv
/*
 * Far-side lookup model: answers each prefetch lookup as hit or miss.
 * Assumes pf_valid pulses for one clk cycle.
 */
module crd_mem_model (
    // Clock and lookup request
    input wire logic clk,
    input wire logic pf_valid,
    // Answer style
    input wire logic miss_mode,
    input wire logic [1:0] lag,
    // Lookup result
    output logic pf_result_valid,
    output logic pf_result_miss
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt = 3'h0;
    initial pf_result_valid = 1'b0;
    initial pf_result_miss = 1'b0;
    // =========================================================
    // Answer lag + 1 cycles after the lookup
    // miss_mode reported as the result
    always @(posedge clk) begin
        pf_result_valid <= 1'b0;
        // Idle line toggles so a stale answer is never trusted
        pf_result_miss <= ~pf_result_miss;
        if (pf_valid === 1'b1) begin
            cnt <= {1'b0, lag} + 3'h1;
        end else if (cnt == 3'h1) begin
            pf_result_valid <= 1'b1;
            pf_result_miss <= miss_mode;
            cnt <= 3'h0;
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
        end
    end
endmodule : crd_mem_model

//--- tb/tb.sv
/*
 * Bench for crd_ctl: APB and request tasks, expected-value checks.
 * Assumes crd_pkg, crd_ctl and crd_mem_model are compiled first.
 */
module tb import crd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // =========================================================
    // Signals
    localparam logic [11:0] S_START = 12'h123;
    localparam logic [11:0] S_END = 12'h456;
    localparam logic [5:0] W = 6'h20, C = 6'h10, WB = 6'h08;
    localparam logic [5:0] AL = 6'h04, H = 6'h02, D = 6'h01;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, sni = 1'b0, fwa = 1'b0, excl = 1'b0;
    logic req_valid = 1'b0, out_en = 1'b1, miss_mode = 1'b1;
    logic [5:0] attr = 6'h00;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, req_addr = 32'h0;
    logic [2:0] pprot = 3'h0;
    logic [1:0] lag = 2'h0;
    logic [31:0] prdata, pf_addr, rd_data, pa;
    logic pready, pslverr, req_ready, dec_valid, pf_valid, pf_fill;
    logic pf_rv, pf_rm, perr, pv;
    logic [6:0] dec_out, dec;
    int err_total = 0, n_tests = 0, cycles = 0, fills = 0;
    logic [32:0] rtab [4] = '{33'h0_6fff_ffff, 33'h1_7000_0000,
        33'h1_7fff_ffff, 33'h0_8000_0000};
    logic [31:0] pfa [5] = '{32'h11f, 32'hf00, 32'hf20, 32'h100, 32'h100};
    logic [5:0] pft [5] = '{C, C, C, W | C, 6'h00};
    logic [31:0] pfe [5] = '{32'h1e1, 32'hfe1, 32'h0, 32'h0, 32'h0};

    crd_ctl dut_u (
        .clk(clk), .rst_n(rst_n), .ce(1'b1),
        .reset_range_start_in(S_START), .reset_range_enable_in(1'b1),
        .reset_range_end_in(S_END), .secure_noninvasive_debug_in(sni),
        .force_walloc_in(fwa), .exclusive_cfg_in(excl), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pprot(pprot), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .slave_zero_input_clk_en(1'b1), .slave_zero_output_clk_en(out_en),
        .req_valid(req_valid), .req_addr(req_addr), .req_write(attr[5]),
        .req_cacheable(attr[4]), .req_write_back(attr[3]),
        .req_alloc(attr[2]), .req_hit(attr[1]), .req_line_dirty(attr[0]),
        .req_ready(req_ready), .dec_valid(dec_valid),
        .dec_route_one(dec_out[6]), .dec_write_through(dec_out[5]),
        .dec_allocate(dec_out[4]), .dec_line_dirty(dec_out[3]),
        .dec_mem_write(dec_out[2]), .dec_cache_write(dec_out[1]),
        .dec_words_only(dec_out[0]), .pf_valid(pf_valid),
        .pf_addr(pf_addr), .pf_result_valid(pf_rv),
        .pf_result_miss(pf_rm), .pf_fill(pf_fill)
    );

    crd_mem_model mem_u (
        .clk(clk), .pf_valid(pf_valid), .miss_mode(miss_mode), .lag(lag),
        .pf_result_valid(pf_rv), .pf_result_miss(pf_rm)
    );

    always #50 clk = ~clk;

    // =========================================================
    // Fill counter and hang guard
    always @(posedge clk) begin
        cycles++;
        if (pf_fill === 1'b1) fills++;
        if (cycles > 3000) begin
            err_total++;
            final_report();
        end
    end

    // =========================================================
    // Tasks
    task final_report();
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    task chk(input string name, input logic [31:0] got,
             input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task apb(input logic wr, input logic [7:0] off, input logic [31:0] wd,
             input logic [2:0] prot);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {24'h0, off};
        pwdata <= wd;
        pprot <= prot;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd_data = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Reads go out non-secure: reads are open to both worlds
    task rchk(input string name, input logic [7:0] off,
              input logic [31:0] exp);
        apb(1'b0, off, 32'h0, 3'h2);
        chk(name, rd_data, exp);
    endtask : rchk

    // Output enable held low for hold cycles delays the decision
    task req(input logic [31:0] a, input logic [5:0] at, input int hold);
        @(posedge clk);
        req_valid <= 1'b1;
        req_addr <= a;
        attr <= at;
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        if (hold > 0) begin
            out_en <= 1'b0;
            repeat (hold) @(posedge clk);
            chk("dec_valid held", 32'(dec_valid), 32'h0);
            out_en <= 1'b1;
        end
        do @(posedge clk); while (dec_valid !== 1'b1);
        dec = dec_out;
        pv = pf_valid;
        pa = pf_addr;
    endtask : req

    // =========================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        rchk("start rst", CRD_OFF_START, {S_START, 20'h1});
        rchk("end rst", CRD_OFF_END, {S_END, 20'h0});
        rchk("debug rst", CRD_OFF_DEBUG, 32'h0);
        rchk("pfoff rst", CRD_OFF_PFOFF, 32'h0);
        req(32'h1230_0000, C, 0);
        chk("route strap in", 32'(dec[6]), 32'h1);
        req(32'h122f_ffff, C, 0);
        chk("route strap out", 32'(dec[6]), 32'h0);
        apb(1'b1, CRD_OFF_END, 32'h800f_ffff, 3'h0);
        rchk("end rw", CRD_OFF_END, 32'h8000_0000);
        apb(1'b1, CRD_OFF_START, 32'h700f_fffe, 3'h0);
        rchk("start rw", CRD_OFF_START, 32'h7000_0000);
        req(32'h7000_0000, C, 0);
        chk("route off", 32'(dec[6]), 32'h0);
        apb(1'b1, CRD_OFF_START, 32'h7000_0001, 3'h0);
        for (int i = 0; i < 4; i++) begin
            req(rtab[i][31:0], C, 0);
            chk("route", 32'(dec[6]), 32'(rtab[i][32]));
        end
        apb(1'b1, CRD_OFF_DEBUG, 32'h3, 3'h2);
        chk("ns write err", 32'(perr), 32'h1);
        rchk("debug kept", CRD_OFF_DEBUG, 32'h0);
        sni <= 1'b1;
        apb(1'b1, CRD_OFF_DEBUG, 32'hffff_fff8, 3'h0);
        chk("s write ok", 32'(perr), 32'h0);
        rchk("debug sni", CRD_OFF_DEBUG, 32'h4);
        apb(1'b0, 8'h14, 32'h0, 3'h0);
        chk("unmapped err", 32'(perr), 32'h1);
        fwa <= 1'b1;
        req(32'h0, W | C | WB | AL, 0);
        chk("normal alloc", 32'(dec[5:4]), 32'h1);
        req(32'h0, W | C | WB | H, 0);
        chk("normal dirty", 32'(dec[3:2]), 32'h2);
        req(32'h0, W | C | WB, 0);
        chk("forced alloc", 32'(dec[4]), 32'h1);
        excl <= 1'b1;
        req(32'h0, W | C | WB | AL, 0);
        chk("excl alloc", 32'(dec[4]), 32'h0);
        excl <= 1'b0;
        apb(1'b1, CRD_OFF_DEBUG, 32'h2, 3'h0);
        req(32'h0, W | C | WB | AL | H, 0);
        chk("fwt clean", 32'(dec[5:2]), 32'h9);
        req(32'h0, W | C | WB | H | D, 0);
        chk("fwt dirty", 32'(dec[5:1]), 32'h17);
        apb(1'b1, CRD_OFF_DEBUG, 32'h1, 3'h0);
        req(32'h0, C | WB | AL, 0);
        chk("lfd read", 32'({dec[4], dec[0]}), 32'h1);
        req(32'h0, W | C | WB | AL, 0);
        chk("lfd write", 32'(dec[4]), 32'h0);
        req(32'h100, C, 0);
        chk("pf off", 32'(pv), 32'h0);
        apb(1'b1, CRD_OFF_AUX, 32'h1000_0000, 3'h0);
        req(32'h100, C, 2);
        chk("pf lfd", pa | 32'(pv), 32'h121);
        repeat (6) @(posedge clk);
        chk("pf lfd no fill", 32'(fills), 32'h0);
        apb(1'b1, CRD_OFF_DEBUG, 32'h0, 3'h0);
        req(32'h100, C, 0);
        repeat (4) @(posedge clk);
        chk("pf fill", 32'(fills), 32'h1);
        apb(1'b1, CRD_OFF_PFOFF, 32'hffff_ffe6, 3'h0);
        rchk("pfoff rw", CRD_OFF_PFOFF, 32'h6);
        apb(1'b1, CRD_OFF_AUX, 32'h2000_0000, 3'h0);
        lag <= 2'h2;
        miss_mode <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            req(pfa[i], pft[i], 0);
            chk("pf", pv ? (pa | 32'h1) : 32'h0, pfe[i]);
        end
        repeat (6) @(posedge clk);
        chk("pf hit no fill", 32'(fills), 32'h1);
        final_report();
    end
endmodule : tb
